// file: ccc_defines.svh
// constants for the configuration stream checksum checker
// assumes nothing; included by the package and the design file
`ifndef CCC_DEFINES_SVH
`define CCC_DEFINES_SVH

// register address codes seen on the write port
`define CCC_ADDR_CHECKSUM 4'h0
`define CCC_ADDR_FRAME_ADDRESS 4'h1
`define CCC_ADDR_FRAME_DATA_INPUT 4'h2
`define CCC_ADDR_COMMAND 4'h4
`define CCC_ADDR_CONTROL 4'h5
`define CCC_ADDR_CONTROL_MASK 4'h6
`define CCC_ADDR_CONFIG_OPTION 4'h9
`define CCC_ADDR_FRAME_LENGTH 4'hB

// x^16 + x^15 + x^2 + 1, x^16 implied
`define CCC_POLY 16'h8005
`define CCC_CRC_RESET_VAL 16'h0000
`define CCC_BITS_PER_CYCLE 9
`define CCC_LAST_PHASE 2'h3
`define CCC_FIFO_DEPTH 16

`endif

// file: ccc_pkg.sv
// types and the one-bit checksum step shared by the checker
// assumes ccc_defines.svh is on the include path
`default_nettype none
`include "ccc_defines.svh"

package ccc_pkg;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] data;
    } ccc_wr_t;

    typedef enum logic {CCC_IDLE, CCC_RUN} ccc_state_t;

    function automatic logic [15:0] ccc_step(input logic [15:0] c, input logic d);
        logic fb;
        fb = d ^ c[15];
        ccc_step = {c[14:0], 1'b0} ^ (fb ? `CCC_POLY : 16'h0000);
    endfunction

    function automatic logic ccc_qualifies(input logic [3:0] a);
        case (a)
            `CCC_ADDR_CHECKSUM,
            `CCC_ADDR_FRAME_ADDRESS,
            `CCC_ADDR_FRAME_DATA_INPUT,
            `CCC_ADDR_COMMAND,
            `CCC_ADDR_CONTROL,
            `CCC_ADDR_CONTROL_MASK,
            `CCC_ADDR_CONFIG_OPTION,
            `CCC_ADDR_FRAME_LENGTH: ccc_qualifies = 1'b1;
            default:                ccc_qualifies = 1'b0;
        endcase
    endfunction

endpackage

`default_nettype wire

// file: ccc_checker.sv
// configuration stream checksum checker: write fifo and 16-bit crc engine
// assumes writes come from packet-processor logic on i_clk, no sync needed
//
// What this block does
// RULE1 - sixteen-bit checksum, polynomial x16+x15+x2+1
// RULE2 - stage zero takes data xor stage fifteen
// RULE3 - stage two takes feedback xor stage one
// RULE4 - stage fifteen takes feedback xor stage fourteen
// RULE5 - checksum reset command clears all stages
// RULE6 - accumulation continues across words and packets
// RULE7 - expected value folded in; nonzero means failure
// RULE8 - only eight listed registers feed checksum
// RULE9 - shift address code and data word
// RULE10 - bits enter least significant first
// RULE11 - address code repeated after every word
// RULE12 - data bits first, then four address bits
// RULE13 - other stream content leaves checksum unchanged
// RULE14 - fixed four-bit codes for listed registers
// RULE15 - parallel update must equal serial model
`timescale 1ns/100ps
`default_nettype none
`include "ccc_defines.svh"

module ccc_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [WIDTH-1:0] mem_nxt [0:DEPTH-1];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    wptr_nxt;
    logic [AW-1:0]    rptr_r;
    logic [AW-1:0]    rptr_nxt;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data  = mem_r[rptr_r];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        mem_nxt   = mem_r;
        wptr_nxt  = wptr_r;
        rptr_nxt  = rptr_r;
        count_nxt = count_r;
        if (push) begin
            mem_nxt[wptr_r] = i_in_data;
            wptr_nxt        = wptr_r + 1'b1;
        end
        if (pop) begin
            rptr_nxt = rptr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wptr_r  <= '0;
            rptr_r  <= '0;
            count_r <= '0;
        end else begin
            mem_r   <= mem_nxt;
            wptr_r  <= wptr_nxt;
            rptr_r  <= rptr_nxt;
            count_r <= count_nxt;
        end
    end

    property p_fifo_full_blocks;
        @(posedge i_clk) disable iff (i_reset)
        (count_r == (AW+1)'(DEPTH) && !pop) |=> count_r == (AW+1)'(DEPTH);
    endproperty
    a_fifo_full_blocks: assert property (p_fifo_full_blocks) // RULE6
        else $error("fifo accepted a word while full");

    property p_fifo_count;
        @(posedge i_clk) disable iff (i_reset)
        (push && !pop) |=> count_r == $past(count_r) + 1'b1;
    endproperty
    a_fifo_count: assert property (p_fifo_count) // RULE6
        else $error("fifo count did not rise on push");

    property p_fifo_drain;
        @(posedge i_clk) disable iff (i_reset)
        (pop && !push) |=> count_r == $past(count_r) - 1'b1;
    endproperty
    a_fifo_drain: assert property (p_fifo_drain) // RULE6
        else $error("fifo count did not fall on pop");

endmodule

module ccc_checker (
    input  wire logic            i_clk,
    input  wire logic            i_reset,
    input  wire logic            i_crc_reset,
    input  wire logic            i_wr_valid,
    input  wire ccc_pkg::ccc_wr_t i_wr,
    output logic                 o_wr_ready,
    output logic [15:0]          o_crc_value,
    output logic                 o_crc_error,
    output logic                 o_check_done
);
    import ccc_pkg::*;

    logic             q_valid;
    logic [35:0]      q_bits;
    ccc_wr_t          q_word;
    logic             pop;
    logic             start;
    logic             done;

    ccc_state_t       state_r;
    ccc_state_t       state_nxt;
    logic [1:0]       phase_r;
    logic [1:0]       phase_nxt;
    logic [35:0]      shreg_r;
    logic [35:0]      shreg_nxt;
    logic [3:0]       addr_r;
    logic [3:0]       addr_nxt;
    logic [15:0]      crc_r;
    logic [15:0]      crc_nxt;
    logic             err_r;
    logic             err_nxt;
    logic             done_r;
    logic             done_nxt;

    logic [15:0]      chain [0:`CCC_BITS_PER_CYCLE];

    // the engine takes five cycles per qualifying word, so the fifo really fills
    ccc_fifo #(
        .WIDTH (36),
        .DEPTH (`CCC_FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_in_valid  (i_wr_valid),
        .i_in_data   (i_wr),
        .o_in_ready  (o_wr_ready),
        .o_out_valid (q_valid),
        .o_out_data  (q_bits),
        .i_out_ready (pop)
    );

    assign q_word = q_bits;

    // nine serial steps per cycle
    assign chain[0] = crc_r;
    for (genvar k = 0; k < `CCC_BITS_PER_CYCLE; k++) begin : g_step
        assign chain[k+1] = ccc_step(chain[k], shreg_r[k]); // RULE1 RULE2 RULE3 RULE4 RULE15
    end

    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        shreg_nxt = shreg_r;
        addr_nxt  = addr_r;
        crc_nxt   = crc_r;
        pop       = 1'b0;
        start     = 1'b0;
        done      = 1'b0;
        case (state_r)
            CCC_IDLE: begin
                if (q_valid) begin
                    pop = 1'b1;
                    // headers, dummies and other registers are dropped here
                    if (ccc_qualifies(q_word.addr)) begin // RULE8 RULE13 RULE14
                        start     = 1'b1;
                        // data low bits go first, address code after each word
                        shreg_nxt = {q_word.addr, q_word.data}; // RULE9 RULE10 RULE11 RULE12
                        addr_nxt  = q_word.addr;
                        phase_nxt = 2'h0;
                        state_nxt = CCC_RUN;
                    end
                end
            end
            CCC_RUN: begin
                crc_nxt   = chain[`CCC_BITS_PER_CYCLE]; // RULE6
                shreg_nxt = shreg_r >> `CCC_BITS_PER_CYCLE; // RULE10
                phase_nxt = phase_r + 2'h1;
                if (phase_r == `CCC_LAST_PHASE) begin
                    done      = 1'b1;
                    state_nxt = CCC_IDLE;
                end
            end
            default: begin
                state_nxt = CCC_IDLE;
            end
        endcase
        // reset command aborts a word still mid-shift
        if (i_crc_reset) begin
            crc_nxt = `CCC_CRC_RESET_VAL; // RULE5
            if (state_r == CCC_RUN && !done) begin
                state_nxt = CCC_IDLE;
            end
        end
    end

    always_comb begin
        err_nxt  = err_r;
        done_nxt = done && (addr_r == `CCC_ADDR_CHECKSUM);
        // a failing check in the reset cycle still sets the flag
        if (done && addr_r == `CCC_ADDR_CHECKSUM && chain[`CCC_BITS_PER_CYCLE] != 16'h0000) begin
            err_nxt = 1'b1; // RULE7
        end else if (i_crc_reset) begin
            err_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= CCC_IDLE;
            phase_r <= 2'h0;
            shreg_r <= '0;
            addr_r  <= 4'h0;
            crc_r   <= `CCC_CRC_RESET_VAL;
            err_r   <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            shreg_r <= shreg_nxt;
            addr_r  <= addr_nxt;
            crc_r   <= crc_nxt;
            err_r   <= err_nxt;
            done_r  <= done_nxt;
        end
    end

    assign o_crc_value  = crc_r;
    assign o_crc_error  = err_r;
    assign o_check_done = done_r;

    // independent bit-serial reference, written tap by tap
    function automatic logic [15:0] ref_serial(input logic [15:0] c, input logic [8:0] b);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = 0; i < 9; i++) begin
            fb = b[i] ^ r[15];
            r  = {r[14] ^ fb, r[13:2], r[1] ^ fb, r[0], fb};
        end
        ref_serial = r;
    endfunction

    logic [15:0] ref_crc;
    assign ref_crc = ref_serial(crc_r, shreg_r[8:0]);

    property p_reset_clears;
        @(posedge i_clk) disable iff (i_reset)
        i_crc_reset |=> crc_r == 16'h0000;
    endproperty
    a_reset_clears: assert property (p_reset_clears) // RULE5
        else $error("checksum not cleared by reset command");

    property p_serial_match;
        @(posedge i_clk) disable iff (i_reset)
        (state_r == CCC_RUN && !i_crc_reset) |=> crc_r == $past(ref_crc);
    endproperty
    a_serial_match: assert property (p_serial_match) // RULE15
        else $error("parallel update differs from serial model");

    property p_word_length;
        @(posedge i_clk) disable iff (i_reset)
        (start && !i_crc_reset) ##1 (!i_crc_reset)[*3] |=> done ##1 (state_r == CCC_IDLE);
    endproperty
    a_word_length: assert property (p_word_length) // RULE12
        else $error("word did not take four shift cycles");

    property p_idle_stable;
        @(posedge i_clk) disable iff (i_reset)
        (state_r == CCC_IDLE && !i_crc_reset) |=> $stable(crc_r);
    endproperty
    a_idle_stable: assert property (p_idle_stable) // RULE13
        else $error("checksum changed without a qualifying word");

    property p_error_set;
        @(posedge i_clk) disable iff (i_reset)
        (done && addr_r == 4'h0 && chain[9] != 16'h0000) |=> o_crc_error ##0 o_check_done;
    endproperty
    a_error_set: assert property (p_error_set) // RULE7
        else $error("failed check not flagged");

    property p_error_hold;
        @(posedge i_clk) disable iff (i_reset)
        (o_crc_error && !i_crc_reset) |=> o_crc_error;
    endproperty
    a_error_hold: assert property (p_error_hold) // RULE7
        else $error("error flag dropped without reset command");

    property p_abort_word;
        @(posedge i_clk) disable iff (i_reset)
        (state_r == CCC_RUN && i_crc_reset && !done) |=> state_r == CCC_IDLE;
    endproperty
    a_abort_word: assert property (p_abort_word) // RULE5
        else $error("reset command did not abort the word in flight");

    property p_skip_other;
        @(posedge i_clk) disable iff (i_reset)
        (state_r == CCC_IDLE && q_valid && !ccc_qualifies(q_word.addr))
            |=> state_r == CCC_IDLE;
    endproperty
    a_skip_other: assert property (p_skip_other) // RULE13
        else $error("word for another register entered the engine");

    property p_start_phase;
        @(posedge i_clk) disable iff (i_reset)
        start |=> state_r == CCC_RUN && phase_r == 2'h0;
    endproperty
    a_start_phase: assert property (p_start_phase) // RULE12
        else $error("qualifying word did not start at the first phase");

    property p_done_pulse;
        @(posedge i_clk) disable iff (i_reset)
        o_check_done |=> !o_check_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) // RULE7
        else $error("check done held longer than one cycle");

    property p_done_source;
        @(posedge i_clk) disable iff (i_reset)
        (done && addr_r != `CCC_ADDR_CHECKSUM) |=> !o_check_done;
    endproperty
    a_done_source: assert property (p_done_source) // RULE8
        else $error("check done raised for another register");

    property p_error_clear;
        @(posedge i_clk) disable iff (i_reset)
        (i_crc_reset && !done) |=> !o_crc_error;
    endproperty
    a_error_clear: assert property (p_error_clear) // RULE7
        else $error("reset command left the error flag set");

endmodule

`default_nettype wire

// file: ccc_writer.sv
// partner model: packet processor offering register writes
// assumes the checker samples valid and data on the rising edge
`timescale 1ns/100ps
`default_nettype none
module ccc_writer (
    input  wire logic             i_clk,
    input  wire logic             i_wr_ready,
    input  wire logic [1:0]       i_slow,
    output var logic              o_wr_valid,
    output var ccc_pkg::ccc_wr_t  o_wr
);
    import ccc_pkg::*;
    ccc_wr_t q[$];
    logic    taken;
    function automatic bit busy();
        return o_wr_valid || q.size() != 0;
    endfunction
    task automatic push(input ccc_wr_t w);
        q.push_back(w);
    endtask
    initial begin
        o_wr_valid = 1'b0;
        o_wr = '0;
        forever begin
            @(posedge i_clk);
            taken = o_wr_valid && i_wr_ready;
            @(negedge i_clk);
            if (taken || !o_wr_valid) begin
                if (q.size() != 0 && $urandom_range(i_slow, 0) == 0) begin
                    o_wr = q.pop_front();
                    o_wr_valid = 1'b1;
                end else begin
                    // released lines show the inverse, so stale data never matches
                    o_wr = ~o_wr;
                    o_wr_valid = 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: config_stream_crc16_checker_tb.sv
// self-checking bench for the configuration stream checksum checker
// assumes ccc_pkg and ccc_writer are compiled first
`timescale 1ns/100ps
`default_nettype none
module config_stream_crc16_checker_tb;
    import ccc_pkg::*;
    logic        i_clk, i_reset, i_crc_reset, i_wr_valid;
    logic        o_wr_ready, o_crc_error, o_check_done, exp_err;
    logic [15:0] o_crc_value, exp_crc;
    logic [1:0]  slow;
    ccc_wr_t     i_wr;
    bit          saw_full;
    int          miscompares, samples_checked;

    ccc_checker i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_crc_reset(i_crc_reset),
        .i_wr_valid(i_wr_valid), .i_wr(i_wr), .o_wr_ready(o_wr_ready),
        .o_crc_value(o_crc_value), .o_crc_error(o_crc_error), .o_check_done(o_check_done));
    ccc_writer i_wr_model (.i_clk(i_clk), .i_wr_ready(o_wr_ready), .i_slow(slow),
        .o_wr_valid(i_wr_valid), .o_wr(i_wr));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (!i_reset && !o_wr_ready) saw_full = 1'b1;

    // bit-serial reference: data bits 0..31, then address bits 0..3
    function automatic logic [15:0] crc_word(logic [15:0] c, logic [3:0] a, logic [31:0] d);
        logic [35:0] s;
        logic        fb;
        s = {a, d};
        for (int i = 0; i < 36; i++) begin
            fb = s[i] ^ c[15];
            c = {c[14:0], fb};
            c[2] = c[2] ^ fb;
            c[15] = c[15] ^ fb;
        end
        return c;
    endfunction
    function automatic bit qual(logic [3:0] a);
        return a inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h9, 4'hB};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (i_wr_model.busy() && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        if (n == 3000) begin
            miscompares++;
            complete_run();
        end
        // full fifo plus engine word, five cycles per qualifying word
        repeat (90) @(negedge i_clk);
    endtask
    task automatic run_words(input int n, input logic [1:0] s, input bit same);
        ccc_wr_t w;
        slow = s;
        w.addr = 4'h2;
        for (int i = 0; i < n; i++) begin
            if (!same) w.addr = 4'($urandom_range(15, 1));
            w.data = $urandom();
            if (qual(w.addr)) exp_crc = crc_word(exp_crc, w.addr, w.data);
            i_wr_model.push(w);
        end
        drain();
        check(o_crc_value, exp_crc, "checksum");
    endtask
    task automatic send_sum(input logic [31:0] d);
        int n;
        i_wr_model.push({4'h0, d});
        exp_crc = crc_word(exp_crc, 4'h0, d);
        exp_err = exp_err | (exp_crc != 16'h0000);
        n = 0;
        while (o_check_done !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check(16'(o_check_done), 16'h0001, "done pulse");
        if (n == 200) complete_run();
        check(16'(o_crc_error), 16'(exp_err), "error flag");
        check(o_crc_value, exp_crc, "final value");
        drain();
    endtask

    initial begin
        logic [31:0] good;
        i_reset = 1'b1;
        i_crc_reset = 1'b0;
        slow = 2'h0;
        exp_crc = 16'h0000;
        exp_err = 1'b0;
        void'($urandom(14659));
        repeat (12) @(posedge i_clk);
        @(negedge i_clk) i_reset = 1'b0;
        check(16'(o_wr_ready), 16'h0001, "ready after reset");
        check(o_crc_value, 16'h0000, "value after reset");
        check(16'(o_crc_error), 16'h0000, "error after reset");
        run_words(40, 2'h0, 1'b0);
        check(16'(saw_full), 16'h0001, "fifo refused when full");
        run_words(6, 2'h0, 1'b1);
        run_words(30, 2'h3, 1'b0);
        good = 32'h0000_0000;
        for (int v = 0; v < 65536; v++) begin
            if (crc_word(exp_crc, 4'h0, 32'(v)) == 16'h0000) begin
                good = 32'(v);
                break;
            end
        end
        send_sum(good);
        send_sum($urandom());
        @(negedge i_clk) i_crc_reset = 1'b1;
        @(negedge i_clk) i_crc_reset = 1'b0;
        check(o_crc_value, 16'h0000, "cleared value");
        check(16'(o_crc_error), 16'h0000, "cleared error");
        // a word arriving while the command is held is aborted and lost
        @(negedge i_clk) i_crc_reset = 1'b1;
        i_wr_model.push({4'h2, 32'h1234_5678});
        repeat (20) @(negedge i_clk);
        i_crc_reset = 1'b0;
        check(o_crc_value, 16'h0000, "aborted word");
        exp_crc = 16'h0000;
        exp_err = 1'b0;
        run_words(10, 2'h1, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
